// File: gate_drive_deadtime_control_tb_top.sv
// self-checking bench for the gate drive dead time block
`timescale 1ns/1ps
module gate_drive_deadtime_control_tb_top;
    import gdtc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [3:0] pstrb;
    logic primary_pwm_in, secondary_pwm_in, overvoltage_active, rd_err;
    logic [7:0] timer2_period, timer1_low_byte;
    logic [7:0] regulation_setpoint_code, external_reference_code;
    logic primary_gate_drive, secondary_gate_drive;
    logic sense_input_pullup_enable;
    logic port_b_pin_1_reference_enable, port_a_pin_1_clock_out_enable;
    int pri_on, sec_on, n_fail = 0, num_checks = 0, cyc = 0;

    gdtc_top u_dut (.*);
    gdtc_mosfet_model u_mos (.*);

    // compare and count
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [7:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        {rd_err, rd_data} = {pslverr, prdata};
        {psel, penable} <= 2'h0;
    endtask

    // read one register and compare error flag and data
    task automatic rd(input logic [11:0] a, input logic e,
        input logic [7:0] d);
        apb(1'b0, a, 8'h00);
        chk({rd_err, rd_data}, {e, 24'h0, d});
    endtask

    // raise both requests and time each turn-on
    task automatic dt_run(input logic [3:0] cp, input logic [3:0] cs,
        input logic [7:0] pe);
        int tp;
        int ts;
        apb(1'b1, ADDR_DEAD_TIME, {cp, cs});
        apb(1'b1, ADDR_PER_EN, pe);
        {tp, ts} = 64'h0;
        {primary_pwm_in, secondary_pwm_in} <= 2'h3;
        for (int n = 1; n < 40; n++) begin
            @(posedge pclk);
            #1;
            if (primary_gate_drive === 1'b1 && tp == 0) tp = n;
            if (secondary_gate_drive === 1'b1 && ts == 0) ts = n;
        end
        chk(33'(tp), 33'(pe[5] ? 1 : 1 + (cp + 1) * DT_STEP_CYC));
        chk(33'(ts), 33'(pe[4] ? 1 : 1 + (cs + 1) * DT_STEP_CYC));
        @(posedge pclk);
        {primary_pwm_in, secondary_pwm_in} <= 2'h0;
        @(posedge pclk);
        #1;
        chk(33'({primary_gate_drive, secondary_gate_drive}), 33'h0);
    endtask

    // steering window of 100 cycles, ten periods of 9+1
    task automatic steer(input logic [7:0] pe, input logic o,
        input int ep, input int es);
        int p0;
        int s0;
        overvoltage_active <= o;
        apb(1'b1, ADDR_PER_EN, pe);
        repeat (20) @(posedge pclk);
        {p0, s0} = {pri_on, sec_on};
        repeat (100) @(posedge pclk);
        chk(33'(pri_on - p0), 33'(ep));
        chk(33'(sec_on - s0), 33'(es));
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // cycle ceiling against hangs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            end_sim();
        end
    end

    // stimulus sequence
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        {primary_pwm_in, secondary_pwm_in, overvoltage_active} = 3'h0;
        {paddr, pwdata, pstrb} = {12'h0, 32'h0, 4'hf};
        {timer2_period, timer1_low_byte} = {8'h09, 8'h04};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(12'(4 * i), 1'b0, 8'h00);
        end
        apb(1'b1, ADDR_REG_DAC, 8'hc3);
        apb(1'b1, ADDR_EXT_DAC, 8'h3c);
        pstrb <= 4'he;
        apb(1'b1, ADDR_REG_DAC, 8'h11);
        pstrb <= 4'hf;
        rd(ADDR_REG_DAC, 1'b0, 8'hc3);
        rd(ADDR_EXT_DAC, 1'b0, 8'h3c);
        chk(33'({regulation_setpoint_code, external_reference_code}),
            33'h0c33c);
        apb(1'b1, ADDR_PER_EN, 8'hff);
        rd(ADDR_PER_EN, 1'b0, 8'hf7);
        // steering off so both dead timers sit idle before timing
        apb(1'b1, ADDR_PER_EN, 8'h00);
        rd(12'h018, 1'b1, 8'h00);
        // every master/slave field value, routing only in master mode
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_MODE, 8'((m << 6) | 8'h3f));
            repeat (2) @(posedge pclk);
            chk(33'({port_b_pin_1_reference_enable,
                port_a_pin_1_clock_out_enable}), 33'({2{m == 1}}));
        end
        rd(ADDR_MODE, 1'b0, 8'hc0);
        // dead time extremes, both drives timed apart, bypass mixes
        dt_run(4'h0, 4'hf, 8'hc0);
        dt_run(4'hf, 4'h0, 8'hc0);
        dt_run(4'h3, 4'h1, 8'hf0);
        dt_run(4'h2, 4'h5, 8'he0);
        // enables gate each drive, clearing drops it at once
        apb(1'b1, ADDR_PER_EN, 8'hb0);
        {primary_pwm_in, secondary_pwm_in} <= 2'h3;
        repeat (3) @(posedge pclk);
        chk(33'({primary_gate_drive, secondary_gate_drive}), 33'h2);
        apb(1'b1, ADDR_PER_EN, 8'h30);
        #1;
        chk(33'({primary_gate_drive, secondary_gate_drive}), 33'h0);
        @(posedge pclk);
        {primary_pwm_in, secondary_pwm_in} <= 2'h0;
        apb(1'b1, ADDR_PER_EN, 8'h04);
        repeat (2) @(posedge pclk);
        chk(33'(sense_input_pullup_enable), 33'h1);
        // steering runs with overvoltage_active on, and off once under secondary steering
        steer(8'hf2, 1'b1, 40, 0);
        steer(8'hf1, 1'b0, 0, 0);
        steer(8'hf1, 1'b1, 0, 40);
        steer(8'hf3, 1'b1, 40, 0);
        end_sim();
    end
endmodule

// File: gdtc_dead_timer.sv
// turn-on delay unit for one low-side drive
`timescale 1ns/1ps
module gdtc_dead_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic drive_req,
    input wire gdtc_pkg::gdtc_drv_cfg_t cfg,
    output logic drive_out
);
    import gdtc_pkg::*;

    gdtc_dt_state_t state;
    logic [DT_CNT_W-1:0] cnt;

    // the longest code must fit the counter
    if (DT_STEP_CYC < 1 || DT_STEP_CYC * 16 > 63) begin : g_chk
        $error("dead time step does not fit the counter");
    end

    // rising edge held off, falling edge passed at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DT_IDLE;
            cnt <= '0;
            drive_out <= 1'b0;
        end else begin
            case (state)
                DT_IDLE: begin
                    cnt <= DT_CNT_W'(1);
                    if (drive_req && cfg.bypass) begin
                        state <= DT_ON;
                        drive_out <= 1'b1;
                    end else if (drive_req) begin
                        state <= DT_WAIT;
                    end
                end
                DT_WAIT: begin
                    if (!drive_req) begin
                        state <= DT_IDLE;
                    end else if (cfg.bypass ||
                                 cnt >= dt_cycles(cfg.code)) begin
                        state <= DT_ON;
                        drive_out <= 1'b1;
                    end else begin
                        cnt <= cnt + DT_CNT_W'(1);
                    end
                end
                DT_ON: begin
                    if (!drive_req) begin
                        state <= DT_IDLE;
                        drive_out <= 1'b0;
                    end
                end
                default: begin
                    state <= DT_IDLE;
                    drive_out <= 1'b0;
                end
            endcase
        end
    end

endmodule

// File: gdtc_mosfet_model.sv
// far side model: power switches that log their conducting cycles
`timescale 1ns/1ps
module gdtc_mosfet_model (
    input wire logic pclk,
    input wire logic primary_gate_drive,
    input wire logic secondary_gate_drive,
    output int pri_on,
    output int sec_on
);
    int p_cnt = 0;
    int s_cnt = 0;

    // a switch conducts through every cycle its gate is driven
    always @(posedge pclk) begin
        p_cnt <= p_cnt + int'(primary_gate_drive === 1'b1);
        s_cnt <= s_cnt + int'(secondary_gate_drive === 1'b1);
    end
    assign pri_on = p_cnt;
    assign sec_on = s_cnt;
endmodule

// File: gdtc_pkg.sv
// shared constants, types and helpers for the gate drive dead time block
package gdtc_pkg;

    // clock and dead time step
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned DT_STEP_NS = 16;
    localparam int unsigned DT_STEP_CYC = (DT_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DT_CNT_W = 6;

    // register byte addresses
    localparam logic [11:0] ADDR_DEAD_TIME = 12'h000;
    localparam logic [11:0] ADDR_REG_DAC = 12'h004;
    localparam logic [11:0] ADDR_EXT_DAC = 12'h008;
    localparam logic [11:0] ADDR_PER_EN = 12'h00c;
    localparam logic [11:0] ADDR_MODE = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;

    // reset values
    localparam logic [7:0] RST_DEAD_TIME = 8'h00;
    localparam logic [7:0] RST_REG_DAC = 8'h00;
    localparam logic [7:0] RST_EXT_DAC = 8'h00;
    localparam logic [7:0] RST_PER_EN = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;

    // writable bit masks
    localparam logic [7:0] MASK_PER_EN = 8'hf7;
    localparam logic [7:0] MASK_MODE = 8'hc0;

    // field positions
    localparam int unsigned DT_PRI_LSB = 4;
    localparam int unsigned DT_SEC_LSB = 0;
    localparam int unsigned PE_PRI_EN = 7;
    localparam int unsigned PE_SEC_EN = 6;
    localparam int unsigned PE_PRI_BY = 5;
    localparam int unsigned PE_SEC_BY = 4;
    localparam int unsigned PE_PULLUP = 2;
    localparam int unsigned PE_STR_PRI = 1;
    localparam int unsigned PE_STR_SEC = 0;
    localparam int unsigned MODE_MSC_LSB = 6;
    localparam logic [1:0] MSC_MASTER = 2'h1;

    // per drive configuration
    typedef struct packed {
        logic enable;
        logic bypass;
        logic [3:0] code;
    } gdtc_drv_cfg_t;

    // dead timer states
    typedef enum logic [2:0] {
        DT_IDLE = 3'b001,
        DT_WAIT = 3'b010,
        DT_ON = 3'b100
    } gdtc_dt_state_t;

    // dead time in clock cycles for a 4-bit code
    function automatic logic [DT_CNT_W-1:0] dt_cycles(input logic [3:0] code);
        dt_cycles = DT_CNT_W'((32'(code) + 1) * DT_STEP_CYC);
    endfunction

endpackage

// File: gdtc_steer_pwm.sv
// fixed frequency open-loop steering pwm
`timescale 1ns/1ps
module gdtc_steer_pwm #(
    parameter int unsigned CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [CNT_W-1:0] period,
    input wire logic [CNT_W-1:0] duty,
    output logic pwm_out
);
    import gdtc_pkg::*;

    logic [CNT_W-1:0] cnt;

    if (CNT_W < 2) begin : g_chk
        $error("steering counter too narrow");
    end

    // period+1 cycles per frame, high while count below duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            pwm_out <= 1'b0;
        end else if (!run) begin
            cnt <= '0;
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (cnt < duty);
            if (cnt >= period) begin
                cnt <= '0;
            end else begin
                cnt <= cnt + CNT_W'(1);
            end
        end
    end

endmodule

// File: gdtc_top.sv
// gate drive dead time and steering control with apb registers
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module gdtc_top #(
    parameter int unsigned STEER_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primary_pwm_in,
    input wire logic secondary_pwm_in,
    input wire logic overvoltage_active,
    input wire logic [STEER_W-1:0] timer2_period,
    input wire logic [STEER_W-1:0] timer1_low_byte,
    output logic primary_gate_drive,
    output logic secondary_gate_drive,
    output logic sense_input_pullup_enable,
    output logic [7:0] regulation_setpoint_code,
    output logic [7:0] external_reference_code,
    output logic port_b_pin_1_reference_enable,
    output logic port_a_pin_1_clock_out_enable
);
    import gdtc_pkg::*;

    // the timer registers are byte wide
    if (STEER_W != 8) begin : g_chk
        $error("steering pwm must be 8 bits wide");
    end

    // register storage
    logic [7:0] gate_dead_time_control;
    logic [7:0] regulation_setpoint_dac;
    logic [7:0] external_reference_dac;
    logic [7:0] driver_peripheral_enable;
    logic [7:0] mode_config;

    // bus decode
    logic setup_phase;
    logic access_phase;
    logic addr_hit;
    logic wr_lane0;
    logic wr_dead;
    logic wr_reg_dac;
    logic wr_ext_dac;
    logic wr_per_en;
    logic wr_mode;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic [7:0] status_byte;

    // drive path
    gdtc_drv_cfg_t pri_cfg;
    gdtc_drv_cfg_t sec_cfg;
    logic steer_pri;
    logic steer_sec;
    logic steer_run;
    logic steer_pwm;
    logic pri_req;
    logic sec_req;
    logic pri_timed;
    logic sec_timed;
    logic [1:0] master_slave_config;

    // true for any address of the register map
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == ADDR_DEAD_TIME) || (a == ADDR_REG_DAC) ||
                    (a == ADDR_EXT_DAC) || (a == ADDR_PER_EN) ||
                    (a == ADDR_MODE) || (a == ADDR_STATUS);
    endfunction

    // write strobe for one register address
    function automatic logic wr_hit(input logic [11:0] a,
                                    input logic [11:0] reg_addr,
                                    input logic strobe);
        wr_hit = strobe && (a == reg_addr);
    endfunction

    // master mode decode of the master/slave field
    function automatic logic is_master(input logic [1:0] msc);
        is_master = (msc == MSC_MASTER);
    endfunction

    // apb phases
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign addr_hit = is_mapped(paddr);

    // zero wait state slave, error on unmapped address
    assign pready = access_phase;
    assign pslverr = access_phase && !addr_hit;

    // writes need byte lane 0, status is read only
    assign wr_lane0 = access_phase && pwrite && pstrb[0];
    assign wr_byte = pwdata[7:0];
    assign wr_dead = wr_hit(paddr, ADDR_DEAD_TIME, wr_lane0);
    assign wr_reg_dac = wr_hit(paddr, ADDR_REG_DAC, wr_lane0);
    assign wr_ext_dac = wr_hit(paddr, ADDR_EXT_DAC, wr_lane0);
    assign wr_per_en = wr_hit(paddr, ADDR_PER_EN, wr_lane0);
    assign wr_mode = wr_hit(paddr, ADDR_MODE, wr_lane0);

    // dead time codes, both nibbles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_dead_time_control <= RST_DEAD_TIME;
        end else if (wr_dead) begin
            gate_dead_time_control <= wr_byte;
        end
    end

    // regulation set-point dac code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulation_setpoint_dac <= RST_REG_DAC;
        end else if (wr_reg_dac) begin
            regulation_setpoint_dac <= wr_byte;
        end
    end

    // external reference dac code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_reference_dac <= RST_EXT_DAC;
        end else if (wr_ext_dac) begin
            external_reference_dac <= wr_byte;
        end
    end

    // enables, bypasses, pull-up and steering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            driver_peripheral_enable <= RST_PER_EN;
        end else if (wr_per_en) begin
            driver_peripheral_enable <= wr_byte & MASK_PER_EN;
        end
    end

    // master and slave mode field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_config <= RST_MODE;
        end else if (wr_mode) begin
            mode_config <= wr_byte & MASK_MODE;
        end
    end

    // live state seen by software
    assign status_byte = {
        2'h0,
        overvoltage_active,
        steer_pwm,
        steer_sec,
        steer_pri,
        secondary_gate_drive,
        primary_gate_drive
    };

    // read data selection
    always_comb begin
        rd_byte = 8'h00;
        case (paddr)
            ADDR_DEAD_TIME: rd_byte = gate_dead_time_control;
            ADDR_REG_DAC: rd_byte = regulation_setpoint_dac;
            ADDR_EXT_DAC: rd_byte = external_reference_dac;
            ADDR_PER_EN: rd_byte = driver_peripheral_enable;
            ADDR_MODE: rd_byte = mode_config;
            ADDR_STATUS: rd_byte = status_byte;
            default: rd_byte = 8'h00;
        endcase
    end

    // read data captured in the setup cycle, upper bits zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // per drive configuration, each drive kept apart
    assign pri_cfg.enable = driver_peripheral_enable[PE_PRI_EN];
    assign pri_cfg.bypass = driver_peripheral_enable[PE_PRI_BY];
    assign pri_cfg.code = gate_dead_time_control[DT_PRI_LSB +: 4];
    assign sec_cfg.enable = driver_peripheral_enable[PE_SEC_EN];
    assign sec_cfg.bypass = driver_peripheral_enable[PE_SEC_BY];
    assign sec_cfg.code = gate_dead_time_control[DT_SEC_LSB +: 4];

    // steering selection, primary dominant
    assign steer_pri = driver_peripheral_enable[PE_STR_PRI];
    assign steer_sec = driver_peripheral_enable[PE_STR_SEC] &&
                       !steer_pri;
    assign steer_run = steer_pri || steer_sec;

    // open-loop pwm from the timer registers
    gdtc_steer_pwm #(
        .CNT_W(STEER_W)
    ) u_steer (
        .pclk(pclk),
        .presetn(presetn),
        .run(steer_run),
        .period(timer2_period),
        .duty(timer1_low_byte),
        .pwm_out(steer_pwm)
    );

    // drive sources before dead time and enable
    always_comb begin
        pri_req = primary_pwm_in;
        sec_req = secondary_pwm_in;
        if (steer_pri) begin
            pri_req = steer_pwm;
            sec_req = 1'b0;
        end else if (steer_sec) begin
            pri_req = 1'b0;
            sec_req = steer_pwm && overvoltage_active;
        end
    end

    // primary turn-on delay, held off while disabled
    gdtc_dead_timer u_pri_dt (
        .pclk(pclk),
        .presetn(presetn),
        .drive_req(pri_req && pri_cfg.enable),
        .cfg(pri_cfg),
        .drive_out(pri_timed)
    );

    // secondary turn-on delay, independent of the primary
    gdtc_dead_timer u_sec_dt (
        .pclk(pclk),
        .presetn(presetn),
        .drive_req(sec_req && sec_cfg.enable),
        .cfg(sec_cfg),
        .drive_out(sec_timed)
    );

    // enable gate on the timed drives, cuts off at once
    assign primary_gate_drive = pri_timed && pri_cfg.enable;
    assign secondary_gate_drive = sec_timed && sec_cfg.enable;

    // weak pull-up control on the sense input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_input_pullup_enable <= 1'b0;
        end else begin
            sense_input_pullup_enable <=
                driver_peripheral_enable[PE_PULLUP];
        end
    end

    // dac codes straight from their registers
    assign regulation_setpoint_code = regulation_setpoint_dac;
    assign external_reference_code = external_reference_dac;

    // master mode pin routing
    assign master_slave_config = mode_config[MODE_MSC_LSB +: 2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_pin_1_reference_enable <= 1'b0;
            port_a_pin_1_clock_out_enable <= 1'b0;
        end else begin
            port_b_pin_1_reference_enable <=
                is_master(master_slave_config);
            port_a_pin_1_clock_out_enable <=
                is_master(master_slave_config);
        end
    end

endmodule

// File: gdtc_top_assertions.sv
// port-level assertions for the gate drive dead time block
`timescale 1ns/1ps
module gdtc_top_checker
    import gdtc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic primary_pwm_in,
    input wire logic secondary_pwm_in,
    input wire logic overvoltage_active,
    input wire logic primary_gate_drive,
    input wire logic secondary_gate_drive,
    input wire logic sense_input_pullup_enable,
    input wire logic [7:0] regulation_setpoint_code,
    input wire logic [7:0] external_reference_code,
    input wire logic port_b_pin_1_reference_enable,
    input wire logic port_a_pin_1_clock_out_enable
);
    logic [7:0] dt, pe, rd, ed;
    logic [1:0] msc;
    logic [5:0] pc, sc, pd, sd;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // register shadow built from completed apb writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {dt, pe, rd, ed, msc} <= 34'h0;
        end else if (psel && penable && pwrite && pstrb[0]) begin
            case (paddr)
                ADDR_DEAD_TIME: dt <= pwdata[7:0];
                ADDR_REG_DAC: rd <= pwdata[7:0];
                ADDR_EXT_DAC: ed <= pwdata[7:0];
                ADDR_PER_EN: pe <= pwdata[7:0] & MASK_PER_EN;
                ADDR_MODE: msc <= pwdata[7:6];
                default: ;
            endcase
        end
    end

    // cycles each request has stayed high, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pc, sc} <= 12'h0;
        end else begin
            pc <= primary_pwm_in ? pc + 6'(pc != 6'h3f) : 6'h00;
            sc <= secondary_pwm_in ? sc + 6'(sc != 6'h3f) : 6'h00;
        end
    end

    // added turn-on delay of each drive in cycles
    assign pd = pe[5] ? 6'h00 : 6'((32'(dt[7:4]) + 1) * DT_STEP_CYC);
    assign sd = pe[4] ? 6'h00 : 6'((32'(dt[3:0]) + 1) * DT_STEP_CYC);

    a_pri_dead_time: assert property (
        primary_pwm_in && pe[7] && pe[1:0] == 2'h0
        |-> primary_gate_drive == (pc > pd))
        else $error("primary turn-on timing wrong");
    a_sec_dead_time: assert property (
        secondary_pwm_in && pe[6] && pe[1:0] == 2'h0
        |-> secondary_gate_drive == (sc > sd))
        else $error("secondary turn-on timing wrong");
    a_pri_fall_fast: assert property (
        $fell(primary_pwm_in) && pe[1:0] == 2'h0 |=> !primary_gate_drive)
        else $error("primary turn-off delayed");
    a_sec_fall_fast: assert property (
        $fell(secondary_pwm_in) && pe[1:0] == 2'h0 |=> !secondary_gate_drive)
        else $error("secondary turn-off delayed");
    a_pri_enable_gate: assert property (
        !pe[7] |-> !primary_gate_drive)
        else $error("primary drives while disabled");
    a_sec_enable_gate: assert property (
        !pe[6] |-> !secondary_gate_drive)
        else $error("secondary drives while disabled");
    a_pullup_follow: assert property (
        sense_input_pullup_enable == $past(pe[2]))
        else $error("pull-up control wrong");
    a_steer_priority: assert property (
        pe[1] [*3] |-> !secondary_gate_drive)
        else $error("secondary pulses under primary steering");
    a_sec_steer_ov: assert property (
        (pe[0] && !overvoltage_active && !secondary_pwm_in) [*3]
        |-> !secondary_gate_drive)
        else $error("secondary pulses without overvoltage");
    a_dac_codes: assert property (
        regulation_setpoint_code == rd && external_reference_code == ed)
        else $error("dac code differs from register");
    a_master_route: assert property (
        port_b_pin_1_reference_enable == $past(msc == MSC_MASTER)
        && port_a_pin_1_clock_out_enable == $past(msc == MSC_MASTER))
        else $error("master routing wrong");
endmodule

bind gdtc_top gdtc_top_checker u_chk (.*);
